// ===== rtl/dfdic_defines.vh
// Register map, field layout, trigger modes and reset values for the acquisition control block
`ifndef DFDIC_DEFINES_VH
`define DFDIC_DEFINES_VH
// Printed offsets (some not multiple of four): register indices, byte address = 4 * index
`define DFDIC_IDX_Q0_THR      8'h14
`define DFDIC_IDX_Q1_THR      8'h16
`define DFDIC_IDX_Q2_THR      8'h18
`define DFDIC_IDX_Q3_THR      8'h1a
`define DFDIC_IDX_COUNT       8'h1c
`define DFDIC_IDX_COUNT_RST   8'h1e
`define DFDIC_IDX_IRQ_ENABLE  8'h20
`define DFDIC_IDX_IRQ_CLEAR   8'h22
`define DFDIC_IDX_IRQ_FLAGS   8'h26
`define DFDIC_IDX_CONTROL     8'h2a
// Field layout
`define DFDIC_THR_W           15
`define DFDIC_CNT_W           16
`define DFDIC_NSRC            9
`define DFDIC_BIT_COUNT_DONE  8
`define DFDIC_BIT_GLOBAL_EN   15
`define DFDIC_BIT_SUMMARY     15
// Control register fields
`define DFDIC_CTL_FRST_LSB    0
`define DFDIC_CTL_MODE_LSB    4
// Trigger modes with a post-trigger count
`define DFDIC_MODE_DELAY      3'h3
`define DFDIC_MODE_ABOUT      3'h4
// Reset values
`define DFDIC_THR_DEFAULT     15'h007f
`define DFDIC_CNT_RESET       16'h0000
`endif

// ===== rtl/dfdic_top.v
// FIFO threshold, post-trigger counter and interrupt control over APB
`timescale 1ns/10ps
`include "dfdic_defines.vh"
module dfdic_top (
  input  wire        clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [3:0]  q_half_full,
  input  wire [3:0]  q_near_full,
  input  wire        trigger_seen,
  input  wire        sample_strobe,
  output wire [59:0] near_empty_offsets,
  output wire [59:0] near_full_offsets,
  output reg  [3:0]  fifo_flush,
  output wire        count_done,
  output wire        irq
);

  // Bus phase qualifiers
  wire        access;        // Access phase
  wire        wr_en;         // Write taking effect
  wire        rd_en;         // Read taking effect
  wire        rd_load;       // First read access cycle, data captured
  wire [7:0]  reg_index;     // Word index from byte address
  wire        aligned;       // Low address bits zero and address in range
  reg         rd_wait;       // Read has had its wait cycle

  // Register map notes for the next engineer:
  // Every register is one aligned 32-bit word on the bus.
  // The printed offsets are word indices, so the byte
  // address on paddr is four times the index.
  // Only the low 16 bits of each word carry data; the
  // upper half reads as zero and is ignored on writes.
  // Reads take one wait cycle: read data is a flop, so
  // it is captured in the first access cycle and shown
  // to the master in the second, when pready rises.
  // Writes complete in the first access cycle.
  // Threshold registers keep two offsets each behind one
  // address; a write pointer and a read pointer pick
  // which one the next access touches. The pointers are
  // independent, so a read never disturbs a write order.
  // A FIFO reset from the control word brings both
  // pointers back to the near-empty offset.
  // Events from the acquisition side arrive as levels in
  // another clock domain; only their rising edges count.
  // Each event must stay high for at least two clock
  // cycles or the synchroniser may miss it.
  // Flags are sticky and only capture enabled sources, so
  // turning a source on later does not raise old events.
  // The clear strobe is refused while any event arrives in
  // the same cycle, so no event can be lost by a clear.
  // Software simply repeats the clear if flags remain.
  // The request output is a pure function of registers,
  // so it never glitches on bus activity.
  // The post-trigger counter only counts in the delay and
  // about trigger modes; any other mode parks it.
  // Loading a count also reloads the samples still to take.
  // The reset strobe reloads from the stored count and
  // clears the terminal count status.
  // A count of zero or one ends on the first sample.
  // Unmapped, misaligned or out-of-range addresses answer
  // with an error and have no effect.

  assign access    = psel & penable;
  assign wr_en     = access & pwrite;
  assign rd_load   = access & ~pwrite & ~rd_wait;
  assign rd_en     = access & ~pwrite & rd_wait;
  assign reg_index = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
  assign pready    = pwrite | rd_wait;

  // One wait cycle on reads for the registered read data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= access & ~pwrite & ~rd_wait;
    end
  end

  // Address decode
  reg         hit_thr;       // One of the threshold registers
  reg  [1:0]  thr_sel;       // Which FIFO
  reg         hit_cnt;       // Counter
  reg         hit_cnt_rst;   // Counter reset strobe
  reg         hit_ien;       // Enables
  reg         hit_iclr;      // Clear strobe
  reg         hit_iflg;      // Flags
  reg         hit_ctl;       // Control
  wire        hit_any;       // Mapped address

  // Index decode as if/else chain
  always @* begin
    hit_thr     = 1'b0;
    thr_sel     = 2'h0;
    hit_cnt     = 1'b0;
    hit_cnt_rst = 1'b0;
    hit_ien     = 1'b0;
    hit_iclr    = 1'b0;
    hit_iflg    = 1'b0;
    hit_ctl     = 1'b0;
    if (!aligned) begin
      hit_thr = 1'b0;  // Misaligned, unmapped
    end else if (reg_index == `DFDIC_IDX_Q0_THR) begin
      hit_thr = 1'b1;
    end else if (reg_index == `DFDIC_IDX_Q1_THR) begin
      hit_thr = 1'b1;
      thr_sel = 2'h1;
    end else if (reg_index == `DFDIC_IDX_Q2_THR) begin
      hit_thr = 1'b1;
      thr_sel = 2'h2;
    end else if (reg_index == `DFDIC_IDX_Q3_THR) begin
      hit_thr = 1'b1;
      thr_sel = 2'h3;
    end else if (reg_index == `DFDIC_IDX_COUNT) begin
      hit_cnt = 1'b1;
    end else if (reg_index == `DFDIC_IDX_COUNT_RST) begin
      hit_cnt_rst = 1'b1;
    end else if (reg_index == `DFDIC_IDX_IRQ_ENABLE) begin
      hit_ien = 1'b1;
    end else if (reg_index == `DFDIC_IDX_IRQ_CLEAR) begin
      hit_iclr = 1'b1;
    end else if (reg_index == `DFDIC_IDX_IRQ_FLAGS) begin
      hit_iflg = 1'b1;
    end else if (reg_index == `DFDIC_IDX_CONTROL) begin
      hit_ctl = 1'b1;
    end
  end

  assign hit_any = hit_thr | hit_cnt | hit_cnt_rst | hit_ien | hit_iclr | hit_iflg | hit_ctl;
  // Error on unmapped, on reading write-only, on writing read-only
  assign pslverr = access & (~hit_any | (~pwrite & (hit_cnt_rst | hit_iclr)) | (pwrite & hit_iflg));

  // Control register: FIFO reset strobes and trigger mode
  reg  [2:0]  trig_mode;     // Acquisition mode
  wire [3:0]  next_flush;    // Reset request per FIFO
  assign next_flush = (wr_en & hit_ctl) ? pwdata[`DFDIC_CTL_FRST_LSB +: 4] : 4'h0;

  // Mode storage and one-cycle flush pulse
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trig_mode  <= 3'h0;
      fifo_flush <= 4'h0;
    end else begin
      fifo_flush <= next_flush;
      if (wr_en & hit_ctl) begin
        trig_mode <= pwdata[`DFDIC_CTL_MODE_LSB +: 3];
      end
    end
  end

  // Threshold registers: two offsets and two sequence pointers per FIFO
  reg  [14:0] near_empty [0:3];  // Near-empty offsets
  reg  [14:0] near_full  [0:3];  // Near-full offsets
  reg  [3:0]  wr_second;         // Next write loads near-full
  reg  [3:0]  rd_second;         // Next read returns near-full
  integer     i;

  // Two-step load and readback per FIFO
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 4; i = i + 1) begin
        near_empty[i] <= `DFDIC_THR_DEFAULT;
        near_full[i]  <= `DFDIC_THR_DEFAULT;
      end
      wr_second <= 4'h0;
      rd_second <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (next_flush[i]) begin
          near_empty[i] <= `DFDIC_THR_DEFAULT;
          near_full[i]  <= `DFDIC_THR_DEFAULT;
          wr_second[i]  <= 1'b0;
          rd_second[i]  <= 1'b0;
        end else if (hit_thr && (thr_sel == i[1:0])) begin
          if (wr_en) begin
            wr_second[i] <= ~wr_second[i];
            if (!wr_second[i]) begin
              near_empty[i] <= pwdata[`DFDIC_THR_W-1:0];
            end else begin
              near_full[i] <= pwdata[`DFDIC_THR_W-1:0];
            end
          end
          if (rd_en) begin
            rd_second[i] <= ~rd_second[i];
          end
        end
      end
    end
  end

  // Offsets out to the FIFO flag logic, held until written or reset
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_thr
      assign near_empty_offsets[g*15 +: 15] = near_empty[g];
      assign near_full_offsets[g*15 +: 15]  = near_full[g];
    end
  endgenerate

  // Event inputs synchronised from acquisition logic
  reg  [9:0]  ev_s1;         // First stage
  reg  [9:0]  ev_s2;         // Second stage
  reg  [9:0]  ev_s3;         // Edge reference
  reg         sample_seen;   // Sample strobe rising edge
  wire [9:0]  ev_rise;

  // Two-flop synchroniser plus edge reference
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_s1 <= 10'h000;
      ev_s2 <= 10'h000;
      ev_s3 <= 10'h000;
    end else begin
      ev_s1 <= {sample_strobe, trigger_seen, q_near_full[3], q_half_full[3], q_near_full[2], q_half_full[2],
                q_near_full[1], q_half_full[1], q_near_full[0], q_half_full[0]};
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end
  assign ev_rise = ev_s2 & ~ev_s3;

  // Post-trigger sample counter
  reg  [15:0] count_load;    // Programmed count
  reg  [15:0] count_left;    // Samples still to take
  reg         counting;      // Counting after trigger
  reg         done_pulse;    // Terminal count event
  reg         done_level;    // Terminal count status
  wire        mode_ok;

  assign mode_ok    = (trig_mode == `DFDIC_MODE_ABOUT) | (trig_mode == `DFDIC_MODE_DELAY);
  assign count_done = done_level;

  // Load, reset, arm on trigger, count down samples
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_load <= `DFDIC_CNT_RESET;
      count_left <= `DFDIC_CNT_RESET;
      counting   <= 1'b0;
      done_pulse <= 1'b0;
      done_level <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (wr_en & hit_cnt_rst) begin
        count_left <= count_load;
        counting   <= 1'b0;
        done_level <= 1'b0;
      end else if (wr_en & hit_cnt) begin
        count_load <= pwdata[`DFDIC_CNT_W-1:0];
        count_left <= pwdata[`DFDIC_CNT_W-1:0];
      end else if (!mode_ok) begin
        counting <= 1'b0;
      end else if (!counting && !done_level && ev_rise[8]) begin
        counting <= 1'b1;
      end else if (counting && ev_rise[9]) begin
        if (count_left <= 16'h0001) begin
          count_left <= 16'h0000;
          counting   <= 1'b0;
          done_pulse <= 1'b1;
          done_level <= 1'b1;
        end else begin
          count_left <= count_left - 16'h0001;
        end
      end
    end
  end

  // Interrupt enables, flags and clear
  reg  [8:0]  src_enable;    // Per-source enables
  reg         global_irq_enable;
  reg  [8:0]  event_flags;   // Sticky flags
  wire [8:0]  src_event;     // Events this cycle
  wire        summary_irq_flag;

  assign src_event        = {done_pulse, ev_rise[7:0]};
  assign summary_irq_flag = |event_flags;
  assign irq = global_irq_enable & |(event_flags & src_enable);

  // Enable storage and sticky flag capture
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_enable        <= 9'h000;
      global_irq_enable <= 1'b0;
      event_flags       <= 9'h000;
    end else begin
      if (wr_en & hit_ien) begin
        src_enable        <= pwdata[`DFDIC_NSRC-1:0];
        global_irq_enable <= pwdata[`DFDIC_BIT_GLOBAL_EN];
      end
      if ((wr_en & hit_iclr) && (src_event == 9'h000)) begin
        event_flags <= 9'h000;
      end else begin
        event_flags <= event_flags | (src_event & src_enable);
      end
    end
  end

  // Read data mux, registered in the first read access cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_load) begin
      if (hit_thr) begin
        prdata <= {17'h0_0000, rd_second[thr_sel] ? near_full[thr_sel] : near_empty[thr_sel]};
      end else if (hit_cnt) begin
        prdata <= {16'h0000, count_left};
      end else if (hit_ien) begin
        prdata <= {16'h0000, global_irq_enable, 6'h00, src_enable};
      end else if (hit_iflg) begin
        prdata <= {16'h0000, summary_irq_flag, 6'h00, event_flags};
      end else if (hit_ctl) begin
        prdata <= {25'h000_0000, trig_mode, 4'h0};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ===== dv/dfdic_chk.sv
// Checker for the APB answer, FIFO reset and threshold behaviour
`timescale 1ns/10ps
module dfdic_chk (
  input wire        clk,
  input wire        nrst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [59:0] near_empty_offsets,
  input wire [59:0] near_full_offsets,
  input wire [3:0]  fifo_flush,
  input wire        count_done
);
  reg wr_d; // Write access seen one edge ago
  // Remember the last write access
  always @(posedge clk or negedge nrst) begin
    if (!nrst) wr_d <= 1'b0;
    else wr_d <= psel && penable && pwrite;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Access phase, and a write access to one place
  sequence s_acc; psel && penable; endsequence
  sequence s_wr(a); psel && penable && pwrite && paddr == a; endsequence
  a_ready_zero: assert property (s_acc ##0 pwrite |-> pready) else $error("pready low in write access");
  a_read_wait: assert property (s_acc ##0 !pwrite ##0 !pready |=> pready) else $error("read wait too long");
  a_err_range: assert property (s_acc ##0 paddr[11:10] != 2'h0 |-> pslverr) else $error("no error out of range");
  a_err_align: assert property (s_acc ##0 paddr[1:0] != 2'h0 |-> pslverr) else $error("no error misaligned");
  a_err_wo_read: assert property (s_acc ##0 !pwrite && (paddr == 12'h078 || paddr == 12'h088) |-> pslverr)
    else $error("strobe read accepted");
  a_err_ro_write: assert property (s_wr(12'h098) |-> pslverr) else $error("flag write accepted");
  a_flush_pulse: assert property (s_wr(12'h0a8) ##0 pwdata[0] |=> fifo_flush[0] ##1 !fifo_flush[0])
    else $error("flush pulse wrong");
  a_flush_default: assert property (fifo_flush[0] |-> ##[0:2] (near_empty_offsets[14:0] == 15'h007f &&
    near_full_offsets[14:0] == 15'h007f)) else $error("offsets not default after flush");
  a_thr_hold: assert property (!$stable(near_empty_offsets) || !$stable(near_full_offsets) |->
    wr_d || fifo_flush != 4'h0 || $past(fifo_flush) != 4'h0) else $error("offset changed on its own");
  a_done_clear: assert property (s_wr(12'h078) |=> !count_done) else $error("done not cleared");
endmodule

// ===== dv/dfdic_src.sv
// Model of the FIFO status lines and trigger and sample sources
`timescale 1ns/10ps
module dfdic_src (
  input wire       clk,
  output reg [3:0] q_half_full,
  output reg [3:0] q_near_full,
  output reg       trigger_seen,
  output reg       sample_strobe
);
  initial {q_half_full, q_near_full, trigger_seen, sample_strobe} = 10'h000;
  // One rising event: 0 half-full, 1 near-full, 2 trigger, 3 sample
  task pulse(input integer k, input integer n);
    begin
      @(posedge clk);
      case (k)
        0: q_half_full[n] <= 1'b1;
        1: q_near_full[n] <= 1'b1;
        2: trigger_seen <= 1'b1;
        default: sample_strobe <= 1'b1;
      endcase
      // Long enough for the two-flop synchroniser
      repeat (4) @(posedge clk);
      {q_half_full, q_near_full, trigger_seen, sample_strobe} <= 10'h000;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// ===== dv/dfdic_tb_top.sv
// Self-checking bench for the acquisition control block
`timescale 1ns/10ps
`include "dfdic_defines.vh"
module dfdic_tb_top;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, trigger_seen, sample_strobe, count_done, irq;
  wire [3:0]  q_half_full, q_near_full, fifo_flush;
  wire [59:0] ne, nf;
  integer     num_errors = 0, n_checks = 0, n, m, i;
  integer     exp_ne[0:3], exp_nf[0:3]; // Model of the offsets
  reg  [31:0] seed, rd;
  reg         err;
  always #12.5 clk = ~clk;
  dfdic_top u_dfdic_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .q_half_full(q_half_full),
    .q_near_full(q_near_full), .trigger_seen(trigger_seen), .sample_strobe(sample_strobe),
    .near_empty_offsets(ne), .near_full_offsets(nf), .fifo_flush(fifo_flush), .count_done(count_done), .irq(irq));
  dfdic_src u_dfdic_src (.clk(clk), .q_half_full(q_half_full), .q_near_full(q_near_full),
    .trigger_seen(trigger_seen), .sample_strobe(sample_strobe));
  // Xorshift source of offsets
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [8*12-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One APB transfer; answer and read data taken at the pready edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 50);
      err = pslverr;
      rd = prdata;
      {psel, penable} <= 2'b00;
      if (k >= 50) begin
        num_errors = num_errors + 1;
        end_sim;
      end
      #1;
    end
  endtask
  task chk_thr(input integer q);
    begin
      chk("near_empty", exp_ne[q], {17'h0, ne[15*q +: 15]});
      chk("near_full", exp_nf[q], {17'h0, nf[15*q +: 15]});
    end
  endtask
  initial begin
    seed = 32'h4ef4;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (n = 0; n < 4; n = n + 1) begin
      exp_ne[n] = 32'h7f;
      exp_nf[n] = 32'h7f;
      chk_thr(n);
    end
    $display("test reset done");
    for (n = 0; n < 4; n = n + 1) begin
      seed = xs(seed);
      exp_ne[n] = seed[14:0];
      seed = xs(seed);
      exp_nf[n] = seed[14:0];
      apb(1'b1, 12'h050 + 8 * n, exp_ne[n]);
      apb(1'b1, 12'h050 + 8 * n, exp_nf[n]);
      chk_thr(n);
      apb(1'b0, 12'h050 + 8 * n, 32'h0);
      chk("thr_read1", exp_ne[n], rd);
      apb(1'b0, 12'h050 + 8 * n, 32'h0);
      chk("thr_read2", exp_nf[n], rd);
    end
    // Reset FIFOs 0 and 2 only
    apb(1'b1, 12'h0a8, 32'h5);
    {exp_ne[0], exp_nf[0], exp_ne[2], exp_nf[2]} = {4{32'h7f}};
    repeat (2) @(posedge clk);
    for (n = 0; n < 4; n = n + 1) chk_thr(n);
    apb(1'b1, 12'h050, 32'h1234);
    exp_ne[0] = 32'h1234;
    chk_thr(0);
    apb(1'b0, 12'h050, 32'h0);
    chk("thr_read1", 32'h1234, rd);
    apb(1'b0, 12'h078, 32'h0);
    chk("err_wo", 32'h1, err);
    apb(1'b1, 12'h400, 32'h0);
    chk("err_range", 32'h1, err);
    $display("test thresholds done");
    apb(1'b1, 12'h080, 32'h8001);
    u_dfdic_src.pulse(0, 0);
    chk("irq", 32'h1, irq);
    u_dfdic_src.pulse(1, 0);
    apb(1'b0, 12'h098, 32'h0);
    chk("flags", 32'h8001, rd);
    apb(1'b1, 12'h088, 32'h0);
    chk("irq", 32'h0, irq);
    apb(1'b0, 12'h098, 32'h0);
    chk("flags", 32'h0, rd);
    apb(1'b1, 12'h080, 32'h0008);
    u_dfdic_src.pulse(1, 1);
    chk("irq", 32'h0, irq);
    apb(1'b1, 12'h080, 32'h8008);
    chk("irq", 32'h1, irq);
    apb(1'b0, 12'h098, 32'h0);
    chk("flags", 32'h8008, rd);
    $display("test interrupts done");
    for (m = 2; m < 5; m = m + 1) begin
      apb(1'b1, 12'h0a8, m << 4);
      apb(1'b1, 12'h070, 32'h3);
      apb(1'b1, 12'h078, 32'h0);
      apb(1'b1, 12'h088, 32'h0);
      chk("count_done", 32'h0, count_done);
      apb(1'b1, 12'h080, 32'h8100);
      u_dfdic_src.pulse(2, 0);
      for (i = 0; i < 3; i = i + 1) u_dfdic_src.pulse(3, 0);
      chk("count_done", m != 2, count_done);
      chk("irq", m != 2, irq);
      apb(1'b0, 12'h098, 32'h0);
      chk("flags", (m != 2) ? 32'h8100 : 32'h0, rd);
    end
    $display("test counter done");
    end_sim;
  end
endmodule
bind dfdic_top dfdic_chk u_dfdic_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .near_empty_offsets(near_empty_offsets),
  .near_full_offsets(near_full_offsets), .fifo_flush(fifo_flush), .count_done(count_done));
